/* pkg/smrm_pkg.sv */
// Shared constants and types for the sensor measurement register map.
package smrm_pkg;

   // Clock and refresh timing.
   localparam int unsigned CLOCK_HZ = 25_000_000;
   localparam int unsigned REFRESH_PERIOD_MS = 110;
   localparam int unsigned REFRESH_CYCLES = REFRESH_PERIOD_MS * (CLOCK_HZ / 1000);

   // Bus widths.
   localparam int unsigned WORD_W = 16;
   localparam int unsigned ADDR_W = 16;

   // First layout: measurement and identity offsets.
   localparam logic [15:0] ADDR_COMPENSATED_IRRADIANCE = 16'h0005;
   localparam logic [15:0] ADDR_RAW_IRRADIANCE = 16'h0006;
   localparam logic [15:0] ADDR_SENSOR_TEMPERATURE = 16'h0008;
   localparam logic [15:0] ADDR_SUPPLY_VOLTAGE = 16'h0009;
   localparam logic [15:0] ADDR_ADC_READING = 16'h0012;
   localparam logic [15:0] ADDR_COMPAT_FIRMWARE_VERSION = 16'h002b;
   localparam logic [15:0] ADDR_COMPAT_HARDWARE_VERSION = 16'h002c;
   localparam logic [15:0] ADDR_COMPAT_SLAVE_ADDRESS = 16'h002d;

   // First layout: fixed constant words.
   localparam logic [15:0] ADDR_PRI_FIX0 = 16'h0000;
   localparam logic [15:0] ADDR_PRI_FIX1 = 16'h0001;
   localparam logic [15:0] ADDR_PRI_FIX2 = 16'h0002;
   localparam logic [15:0] ADDR_PRI_FIX4 = 16'h0004;
   localparam logic [15:0] ADDR_PRI_YEAR = 16'h0029;
   localparam logic [15:0] PRI_FIX0_VALUE = 16'hffff;
   localparam logic [15:0] PRI_FIX1_VALUE = 16'h0064;
   localparam logic [15:0] PRI_FIX2_VALUE = 16'h0001;
   localparam logic [15:0] PRI_FIX4_VALUE = 16'h0001;
   localparam logic [15:0] PRI_YEAR_VALUE = 16'h07e4;

   // Second layout offsets.
   localparam logic [15:0] ADDR_ALT_SLAVE_ADDRESS = 16'h0000;
   localparam logic [15:0] ADDR_ALT_LINK_SETTING = 16'h0001;
   localparam logic [15:0] ADDR_ALT_COMPENSATED_IRRADIANCE = 16'h0002;
   localparam logic [15:0] ADDR_ALT_RAW_IRRADIANCE = 16'h0004;
   localparam logic [15:0] ADDR_ALT_SENSOR_TEMPERATURE = 16'h0006;
   localparam logic [15:0] ADDR_ALT_FIX8 = 16'h0008;
   localparam logic [15:0] ADDR_ALT_FIX9 = 16'h0009;
   localparam logic [15:0] ADDR_ALT_ADC_READING = 16'h000a;
   localparam logic [15:0] ADDR_ALT_SENSOR_LABEL = 16'h0020;
   localparam logic [15:0] ADDR_ALT_SENSOR_LABEL_LAST = 16'h0027;
   localparam logic [15:0] ADDR_ALT_SENSITIVITY = 16'h0029;
   localparam logic [15:0] ADDR_ALT_CALIBRATION_DATE = 16'h002e;
   localparam logic [15:0] ALT_FIX8_VALUE = 16'h0064;
   localparam logic [15:0] ALT_FIX9_VALUE = 16'h0064;

   // Upper region.
   localparam logic [15:0] ADDR_RESERVED_FIRST = 16'h0032;
   localparam logic [15:0] ADDR_RESERVED_LAST = 16'h005f;
   localparam logic [15:0] ADDR_MAKER_NAME = 16'h0060;
   localparam logic [15:0] ADDR_FIRMWARE_VERSION = 16'h0062;
   localparam logic [15:0] ADDR_HARDWARE_VERSION = 16'h0063;
   localparam logic [7:0] MAKER_PAD_CHAR = 8'h20;

   // Reset values.
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [31:0] DWORD_RESET = 32'h0000_0000;

   // One atomic measurement snapshot.
   typedef struct packed {
      logic [15:0] comp_irr_w;
      logic [15:0] raw_irr_w;
      logic [31:0] comp_irr_centi;
      logic [31:0] raw_irr_centi;
      logic [15:0] temp_deci;
      logic [15:0] temp_centi;
      logic [15:0] supply_deci;
      logic [31:0] adc_centi_uv;
      logic [31:0] adc_nv;
      logic [15:0] tilt_angle;
      logic [31:0] cal_date;
   } smrm_snap_t;

endpackage : smrm_pkg

/* src/smrm_refresh_timer.sv */
// Free-running refresh tick generator for the measurement snapshot.
`timescale 1ns/100ps
`default_nettype none
module smrm_refresh_timer #(
   parameter int unsigned PERIOD = smrm_pkg::REFRESH_CYCLES
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clk_en,
   output logic tick
);
   import smrm_pkg::*;

   localparam logic [31:0] LAST = 32'(PERIOD - 1);

   typedef struct packed {
      logic [31:0] count;
      logic tick;
   } smrm_timer_state_t;

   smrm_timer_state_t s_r;
   smrm_timer_state_t s_nxt;

   initial begin
      if (PERIOD < 2) begin
         $error("Refresh period must be at least two cycles.");
      end
   end

   // Starting at the last count makes the first tick fall right after reset.
   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = (s_r.count == LAST);
      s_nxt.count = (s_r.count == LAST) ? 32'h0000_0000 : s_r.count + 32'h0000_0001;
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         s_r.count <= LAST;
         s_r.tick <= 1'b0;
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick;

   AST_TICK_AT_WRAP: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && s_r.count == LAST) |=> s_r.tick)
      else $error("Refresh tick missing at the end of the period.");

   AST_TICK_SPACING: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && s_r.tick && s_r.count == 32'h0000_0000) |=> (!s_r.tick || !clk_en))
      else $error("Refresh ticks closer than one period.");

endmodule : smrm_refresh_timer
`default_nettype wire

/* src/smrm_register_map.sv */
// Read-only measurement and identity register bank of the irradiance sensor.
`timescale 1ns/100ps
`default_nettype none
module smrm_register_map #(
   parameter int unsigned REFRESH_CYCLES = smrm_pkg::REFRESH_CYCLES,
   // Arbitrary neutral maker name; the low character must stay a space.
   parameter logic [31:0] MAKER_NAME = 32'h4142_4320
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic rd_en,
   input wire logic [smrm_pkg::ADDR_W-1:0] rd_addr,
   output logic rd_valid,
   output logic [smrm_pkg::WORD_W-1:0] rd_data,
   input wire logic layout_alt,
   input wire logic [15:0] cfg_slave_address,
   input wire logic [15:0] cfg_link_setting,
   output logic [15:0] active_slave_address,
   output logic [15:0] active_link_setting,
   input wire logic [15:0] comp_irr_w,
   input wire logic [15:0] raw_irr_w,
   input wire logic [31:0] comp_irr_centi,
   input wire logic [31:0] raw_irr_centi,
   input wire logic [15:0] temp_deci,
   input wire logic [15:0] temp_centi,
   input wire logic [15:0] supply_deci,
   input wire logic [31:0] adc_centi_uv,
   input wire logic [31:0] adc_nv,
   input wire logic [15:0] tilt_angle,
   input wire logic [31:0] cal_date,
   input wire logic [127:0] sensor_label,
   input wire logic [31:0] sensitivity,
   input wire logic [15:0] firmware_version,
   input wire logic [15:0] hardware_version,
   output logic [15:0] latched_tilt_angle,
   output logic refresh_done
);
   import smrm_pkg::*;

   typedef struct packed {
      logic rd_valid;
      logic [15:0] rd_data;
      logic link_held;
      logic [15:0] active_addr;
      logic [15:0] active_link;
      logic refresh_done;
      smrm_snap_t snap;
   } smrm_map_state_t;

   smrm_map_state_t s_r;
   smrm_map_state_t s_nxt;
   logic tick;

   initial begin
      if (MAKER_NAME[7:0] != MAKER_PAD_CHAR) begin
         $error("Maker name must end in a space character.");
      end
   end

   // High word sits at the lower address, as usual for the serial bus.
   function automatic logic [15:0] dword_half(input logic [31:0] v, input logic [15:0] base,
                                              input logic [15:0] a);
      dword_half = (a == base) ? v[31:16] : v[15:0];
   endfunction : dword_half

   smrm_refresh_timer #(
      .PERIOD(REFRESH_CYCLES)
   ) u_timer (
      .clock(clock),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .tick(tick)
   );

   always_comb begin
      s_nxt = s_r;
      s_nxt.refresh_done = tick;
      // Whole snapshot moves in one edge so both halves of a pair always agree.
      if (tick) begin
         s_nxt.snap.comp_irr_w = comp_irr_w;
         s_nxt.snap.raw_irr_w = raw_irr_w;
         s_nxt.snap.comp_irr_centi = comp_irr_centi;
         s_nxt.snap.raw_irr_centi = raw_irr_centi;
         s_nxt.snap.temp_deci = temp_deci;
         s_nxt.snap.temp_centi = temp_centi;
         s_nxt.snap.supply_deci = supply_deci;
         s_nxt.snap.adc_centi_uv = adc_centi_uv;
         s_nxt.snap.adc_nv = adc_nv;
         s_nxt.snap.tilt_angle = tilt_angle;
         s_nxt.snap.cal_date = cal_date;
      end
      // Link settings are caught once after reset; later writes wait for the next restart.
      if (!s_r.link_held) begin
         s_nxt.link_held = 1'b1;
         s_nxt.active_addr = cfg_slave_address;
         s_nxt.active_link = cfg_link_setting;
      end
      s_nxt.rd_valid = rd_en;
      s_nxt.rd_data = WORD_RESET;
      if (rd_en) begin
         if (rd_addr >= ADDR_RESERVED_FIRST && rd_addr <= ADDR_RESERVED_LAST) begin
            s_nxt.rd_data = WORD_RESET;
         end else if (rd_addr == ADDR_MAKER_NAME) begin
            s_nxt.rd_data = MAKER_NAME[31:16];
         end else if (rd_addr == ADDR_MAKER_NAME + 16'h0001) begin
            s_nxt.rd_data = {MAKER_NAME[15:8], MAKER_PAD_CHAR};
         end else if (rd_addr == ADDR_FIRMWARE_VERSION) begin
            s_nxt.rd_data = firmware_version;
         end else if (rd_addr == ADDR_HARDWARE_VERSION) begin
            s_nxt.rd_data = hardware_version;
         end else if (!layout_alt) begin
            case (rd_addr)
               ADDR_PRI_FIX0: s_nxt.rd_data = PRI_FIX0_VALUE;
               ADDR_PRI_FIX1: s_nxt.rd_data = PRI_FIX1_VALUE;
               ADDR_PRI_FIX2: s_nxt.rd_data = PRI_FIX2_VALUE;
               ADDR_PRI_FIX4: s_nxt.rd_data = PRI_FIX4_VALUE;
               ADDR_COMPENSATED_IRRADIANCE: s_nxt.rd_data = s_r.snap.comp_irr_w;
               ADDR_RAW_IRRADIANCE: s_nxt.rd_data = s_r.snap.raw_irr_w;
               ADDR_SENSOR_TEMPERATURE: s_nxt.rd_data = s_r.snap.temp_deci;
               ADDR_SUPPLY_VOLTAGE: s_nxt.rd_data = s_r.snap.supply_deci;
               ADDR_ADC_READING, ADDR_ADC_READING + 16'h0001: begin
                  s_nxt.rd_data = dword_half(s_r.snap.adc_centi_uv, ADDR_ADC_READING, rd_addr);
               end
               ADDR_PRI_YEAR: s_nxt.rd_data = PRI_YEAR_VALUE;
               ADDR_COMPAT_FIRMWARE_VERSION: s_nxt.rd_data = firmware_version;
               ADDR_COMPAT_HARDWARE_VERSION: s_nxt.rd_data = hardware_version;
               ADDR_COMPAT_SLAVE_ADDRESS: s_nxt.rd_data = s_r.active_addr;
               default: s_nxt.rd_data = WORD_RESET;
            endcase
         end else begin
            case (rd_addr)
               ADDR_ALT_SLAVE_ADDRESS: s_nxt.rd_data = s_r.active_addr;
               ADDR_ALT_LINK_SETTING: s_nxt.rd_data = s_r.active_link;
               ADDR_ALT_COMPENSATED_IRRADIANCE, ADDR_ALT_COMPENSATED_IRRADIANCE + 16'h0001: begin
                  s_nxt.rd_data = dword_half(s_r.snap.comp_irr_centi, ADDR_ALT_COMPENSATED_IRRADIANCE,
                                             rd_addr);
               end
               ADDR_ALT_RAW_IRRADIANCE, ADDR_ALT_RAW_IRRADIANCE + 16'h0001: begin
                  s_nxt.rd_data = dword_half(s_r.snap.raw_irr_centi, ADDR_ALT_RAW_IRRADIANCE, rd_addr);
               end
               ADDR_ALT_SENSOR_TEMPERATURE: s_nxt.rd_data = s_r.snap.temp_centi;
               ADDR_ALT_FIX8: s_nxt.rd_data = ALT_FIX8_VALUE;
               ADDR_ALT_FIX9: s_nxt.rd_data = ALT_FIX9_VALUE;
               ADDR_ALT_ADC_READING, ADDR_ALT_ADC_READING + 16'h0001: begin
                  s_nxt.rd_data = dword_half(s_r.snap.adc_nv, ADDR_ALT_ADC_READING, rd_addr);
               end
               ADDR_ALT_SENSITIVITY, ADDR_ALT_SENSITIVITY + 16'h0001: begin
                  s_nxt.rd_data = dword_half(sensitivity, ADDR_ALT_SENSITIVITY, rd_addr);
               end
               ADDR_ALT_CALIBRATION_DATE, ADDR_ALT_CALIBRATION_DATE + 16'h0001: begin
                  s_nxt.rd_data = dword_half(s_r.snap.cal_date, ADDR_ALT_CALIBRATION_DATE, rd_addr);
               end
               default: begin
                  if (rd_addr >= ADDR_ALT_SENSOR_LABEL && rd_addr <= ADDR_ALT_SENSOR_LABEL_LAST) begin
                     s_nxt.rd_data = sensor_label[{3'h7 - rd_addr[2:0], 4'h0} +: 16];
                  end else begin
                     s_nxt.rd_data = WORD_RESET;
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         s_r.rd_valid <= 1'b0;
         s_r.rd_data <= WORD_RESET;
         s_r.link_held <= 1'b0;
         s_r.active_addr <= WORD_RESET;
         s_r.active_link <= WORD_RESET;
         s_r.refresh_done <= 1'b0;
         s_r.snap <= '0;
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end

   assign rd_valid = s_r.rd_valid;
   assign rd_data = s_r.rd_data;
   assign active_slave_address = s_r.active_addr;
   assign active_link_setting = s_r.active_link;
   assign latched_tilt_angle = s_r.snap.tilt_angle;
   assign refresh_done = s_r.refresh_done;

   AST_READ_ANSWER: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && rd_en) |=> rd_valid)
      else $error("Read not answered on the next edge.");

   AST_HOLD_BETWEEN: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && !tick) |=> $stable(s_r.snap))
      else $error("Snapshot changed without a refresh.");

   AST_RESERVED_ZERO: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && rd_en && rd_addr >= ADDR_RESERVED_FIRST && rd_addr <= ADDR_RESERVED_LAST) |=> rd_data == 16'h0000)
      else $error("Reserved register read nonzero.");

   AST_MAKER_HIGH: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && rd_en && rd_addr == ADDR_MAKER_NAME) |=> rd_data == MAKER_NAME[31:16])
      else $error("Maker name first word wrong.");

   AST_MAKER_PAD: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && rd_en && rd_addr == ADDR_MAKER_NAME + 16'h0001) |=> rd_data[7:0] == 8'h20)
      else $error("Maker name pad character wrong.");

   AST_HW_VERSION: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && rd_en && rd_addr == ADDR_HARDWARE_VERSION) |=> rd_data == $past(hardware_version))
      else $error("Hardware version read wrong.");

   AST_COMP_IRR: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && rd_en && !layout_alt && rd_addr == ADDR_COMPENSATED_IRRADIANCE)
      |=> rd_data == $past(s_r.snap.comp_irr_w))
      else $error("Compensated irradiance read wrong.");

   AST_RAW_IRR: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && rd_en && !layout_alt && rd_addr == ADDR_RAW_IRRADIANCE) |=> rd_data == $past(s_r.snap.raw_irr_w))
      else $error("Raw irradiance read wrong.");

   AST_LINK_FROZEN: assert property (@(posedge clock) disable iff (!reset_n)
      s_r.link_held |=> ($stable(active_slave_address) && $stable(active_link_setting)))
      else $error("Active link settings changed before restart.");

   AST_ATOMIC_CAPTURE: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && tick) |=> (s_r.snap.adc_centi_uv == $past(adc_centi_uv) && s_r.snap.cal_date == $past(cal_date)))
      else $error("Refresh did not capture all pairs together.");

endmodule : smrm_register_map
`default_nettype wire

/* test/smrm_host_model.sv */
// Behavioural serial-bus host that polls the register bank one word at a time.
`timescale 1ns/100ps
`default_nettype none
module smrm_host_model (
   input wire logic clock,
   output logic rd_en,
   output logic [smrm_pkg::ADDR_W-1:0] rd_addr
);
   import smrm_pkg::*;

   initial begin
      rd_en = 1'b0;
      rd_addr = 16'h0000;
   end

   // A request is raised after a falling edge and held across exactly one rising edge.
   task read(input logic [ADDR_W-1:0] a);
      rd_en = 1'b1;
      rd_addr = a;
      @(negedge clock);
   endtask : read

   // An idle host drops rd_en and inverts the address lines once so a stale address never looks valid.
   task idle();
      rd_en = 1'b0;
      rd_addr = ~rd_addr;
      @(negedge clock);
   endtask : idle
endmodule : smrm_host_model
`default_nettype wire

/* test/smrm_register_map_test.sv */
// Self-checking testbench of the sensor measurement register bank.
`timescale 1ns/100ps
`default_nettype none
module smrm_register_map_test;
   import smrm_pkg::*;
   localparam int unsigned REF = 8;
   // Arbitrary neutral maker name with a space in the last position.
   localparam logic [31:0] MK = 32'h4d4e4f20;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic layout_alt = 1'b0;
   logic [15:0] cfg_a = 16'h0011;
   logic [15:0] cfg_l = 16'h0022;
   logic [15:0] exp_a, exp_l, fw, hw;
   logic [127:0] label;
   logic [31:0] sens;
   logic [31:0] seed = 32'h0000fe44;
   smrm_snap_t meas, snap;
   logic rd_en, rd_valid, refresh_done;
   logic [15:0] rd_addr, rd_data, act_a, act_l, tilt_q;
   logic [15:0] expq[$];
   int mismatches = 0;
   int num_checks = 0;

   always #20 clock = ~clock;

   smrm_host_model i_host (.clock(clock), .rd_en(rd_en), .rd_addr(rd_addr));

   smrm_register_map #(.REFRESH_CYCLES(REF), .MAKER_NAME(MK)) i_dut (
      .clock(clock), .reset_n(reset_n), .clk_en(clk_en), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_valid(rd_valid), .rd_data(rd_data), .layout_alt(layout_alt), .cfg_slave_address(cfg_a),
      .cfg_link_setting(cfg_l), .active_slave_address(act_a), .active_link_setting(act_l),
      .comp_irr_w(meas.comp_irr_w), .raw_irr_w(meas.raw_irr_w), .comp_irr_centi(meas.comp_irr_centi),
      .raw_irr_centi(meas.raw_irr_centi), .temp_deci(meas.temp_deci), .temp_centi(meas.temp_centi),
      .supply_deci(meas.supply_deci), .adc_centi_uv(meas.adc_centi_uv), .adc_nv(meas.adc_nv),
      .tilt_angle(meas.tilt_angle), .cal_date(meas.cal_date), .sensor_label(label),
      .sensitivity(sens), .firmware_version(fw), .hardware_version(hw),
      .latched_tilt_angle(tilt_q), .refresh_done(refresh_done));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic logic [15:0] exp_word(input logic alt, input logic [15:0] a);
      if (a == 16'h0060) return MK[31:16];
      if (a == 16'h0061) return {MK[15:8], 8'h20};
      if (a == 16'h0062) return fw;
      if (a == 16'h0063) return hw;
      if (!alt) begin
         case (a)
            16'h0000: return 16'hffff;
            16'h0001: return 16'h0064;
            16'h0002, 16'h0004: return 16'h0001;
            16'h0005: return snap.comp_irr_w;
            16'h0006: return snap.raw_irr_w;
            16'h0008: return snap.temp_deci;
            16'h0009: return snap.supply_deci;
            16'h0012: return snap.adc_centi_uv[31:16];
            16'h0013: return snap.adc_centi_uv[15:0];
            16'h0029: return 16'h07e4;
            16'h002b: return fw;
            16'h002c: return hw;
            16'h002d: return exp_a;
            default: return 16'h0000;
         endcase
      end
      if (a >= 16'h0020 && a <= 16'h0027) return label[127 - 16 * (a - 16'h0020) -: 16];
      case (a)
         16'h0000: return exp_a;
         16'h0001: return exp_l;
         16'h0002: return snap.comp_irr_centi[31:16];
         16'h0003: return snap.comp_irr_centi[15:0];
         16'h0004: return snap.raw_irr_centi[31:16];
         16'h0005: return snap.raw_irr_centi[15:0];
         16'h0006: return snap.temp_centi;
         16'h0008, 16'h0009: return 16'h0064;
         16'h000a: return snap.adc_nv[31:16];
         16'h000b: return snap.adc_nv[15:0];
         16'h0029: return sens[31:16];
         16'h002a: return sens[15:0];
         16'h002e: return snap.cal_date[31:16];
         16'h002f: return snap.cal_date[15:0];
         default: return 16'h0000;
      endcase
   endfunction : exp_word

   task check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task end_sim();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim

   // Each read notes the word it should return, worked out from the map at request time.
   task rd(input logic [15:0] a);
      expq.push_back(exp_word(layout_alt, a));
      i_host.read(a);
   endtask : rd

   // A pulse already showing on entry is stepped over, so each call waits for a fresh refresh.
   task wait_refresh();
      int n;
      n = 0;
      if (refresh_done === 1'b1) @(negedge clock);
      while (refresh_done !== 1'b1 && n < 64) begin
         @(negedge clock);
         n++;
      end
      if (refresh_done !== 1'b1) mismatches++;
   endtask : wait_refresh

   task drain();
      i_host.idle();
      repeat (3) @(negedge clock);
      check(16'(expq.size()), 16'h0000);
   endtask : drain

   always @(negedge clock) begin
      if (rd_valid === 1'b1) begin
         check(rd_data, expq.size() > 0 ? expq.pop_front() : 16'hxxxx);
      end
   end

   initial begin
      #(40 * 20000);
      mismatches++;
      end_sim();
   end

   initial begin
      int n;
      meas = '0;
      snap = '0;
      fw = 16'h0a1b;
      hw = 16'h0c2d;
      label = {xs(), xs(), xs(), xs()};
      sens = xs();
      repeat (16) @(negedge clock);
      reset_n = 1'b1;
      repeat (2) @(negedge clock);
      check(act_a, cfg_a);
      check(act_l, cfg_l);
      cfg_a = 16'h0033;
      cfg_l = 16'h0044;
      repeat (3) @(negedge clock);
      check(act_a, 16'h0011);
      check(act_l, 16'h0022);
      reset_n = 1'b0;
      repeat (2) @(negedge clock);
      reset_n = 1'b1;
      repeat (2) @(negedge clock);
      check(act_a, 16'h0033);
      check(act_l, 16'h0044);
      exp_a = 16'h0033;
      exp_l = 16'h0044;
      $display("test restart settings done");
      // Inputs stay put for two refreshes so the snapshot must equal them.
      meas = {xs(), xs(), xs(), xs(), xs(), xs(), xs(), xs()};
      wait_refresh();
      wait_refresh();
      snap = meas;
      for (int alt = 0; alt < 2; alt++) begin
         layout_alt = alt[0];
         for (int i = 0; i < 104; i++) rd(i[15:0]);
         rd(16'h00c8);
         rd(16'hffff);
         drain();
      end
      $display("test register sweep done");
      // Live inputs move right after a refresh; reads before the next one still show the old sample.
      layout_alt = 1'b0;
      wait_refresh();
      meas = {xs(), xs(), xs(), xs(), xs(), xs(), xs(), xs()};
      rd(16'h0005);
      rd(16'h0012);
      rd(16'h0013);
      rd(16'h0005);
      i_host.idle();
      wait_refresh();
      snap = meas;
      check(tilt_q, snap.tilt_angle);
      // The poll below ends before the next refresh, as a well-behaved host does.
      rd(16'h0006);
      rd(16'h0012);
      rd(16'h0013);
      drain();
      $display("test held sample done");
      for (int frz = 0; frz <= 5; frz += 5) begin
         wait_refresh();
         n = 0;
         do begin
            @(negedge clock);
            n++;
            clk_en = !(n >= 1 && n <= frz);
         end while (refresh_done !== 1'b1 && n < 64);
         check(16'(n), 16'(REF + frz));
      end
      $display("test refresh period done");
      end_sim();
   end
endmodule : smrm_register_map_test
`default_nettype wire
